// File: spia_map.svh
`ifndef SPIA_MAP_SVH
`define SPIA_MAP_SVH
// Register byte offsets
`define SPIA_OFF_CTRL     8'h00
`define SPIA_OFF_LINK     8'h04
`define SPIA_OFF_STATUS   8'h08
`define SPIA_OFF_MASK     8'h0C
`define SPIA_OFF_WIRES    8'h10
`define SPIA_OFF_MSI_ADDRESS_LOW  8'h14
`define SPIA_OFF_MSIADDRH 8'h18
// Control register field positions, per port p: bits 4p+k
`define SPIA_CTRL_MSIEN   0
`define SPIA_CTRL_INTXDIS 1
`define SPIA_CTRL_BWNEN   2
`define SPIA_CTRL_ABWNEN  3
// Interrupt status bit positions
`define SPIA_IRQ_MSI      0
`define SPIA_IRQ_ASSERT   1
`define SPIA_IRQ_DEASSERT 2
// Reset values
`define SPIA_RST_CTRL     32'h0000_0000
`define SPIA_RST_MASK     32'h0000_0000
`endif

// File: spia_pkg.sv
package spia_pkg;
	// One INTx message toward the root
	typedef struct packed {
		logic       valid;
		logic       assert_n_deassert;
		logic [1:0] wire_idx;
	} spia_intx_msg_t;
	// One MSI request toward the upstream port
	typedef struct packed {
		logic       valid;
		logic [2:0] port;
	} spia_msi_req_t;
	// Per-port virtual-wire send state
	typedef enum logic [0:0] {SPIA_VW_IDLE, SPIA_VW_HELD} spia_vw_t;
endpackage

// File: spia_aggregator.sv
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "spia_map.svh"
module spia_aggregator #(
	parameter int NPORTS = 4
) (
	// Clock, reset, enable
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire logic                         ce_i,
	// Wishbone slave
	input  wire logic                         cyc_i,
	input  wire logic                         stb_i,
	input  wire logic                         we_i,
	input  wire logic [7:0]                   adr_i,
	input  wire logic [3:0]                   sel_i,
	input  wire logic [31:0]                  dat_i,
	output logic      [31:0]                  dat_o,
	output logic                              ack_o,
	// Per-port sources and state (pins, synchronised)
	input  wire logic [NPORTS-1:0]            hp_irq_i,
	input  wire logic [NPORTS-1:0]            dl_up_i,
	input  wire logic [NPORTS-1:0]            in_part_i,
	input  wire logic [NPORTS*4-1:0]          ext_intx_i,
	// Message and interrupt outputs
	output spia_pkg::spia_intx_msg_t          intx_msg_o,
	output spia_pkg::spia_msi_req_t           msi_req_o,
	output logic                              irq_o
);
	// Synchronisers for pin inputs
	logic [NPORTS*7-1:0] sync1;
	logic [NPORTS*7-1:0] sync2;
	// Software registers
	logic [31:0] ctrl;
	logic [31:0] mask;
	logic [31:0] status;
	logic [31:0] msi_lo;
	logic [31:0] msi_hi;
	// Link bandwidth status bits, W1C: [2p]=mgmt, [2p+1]=autonomous
	logic [2*NPORTS-1:0] link_bw;
	// Per-port and upstream wire state
	logic [NPORTS-1:0] cond_q;
	logic [NPORTS-1:0] inta_q;
	logic [3:0]        up_q;
	logic [3:0]        sent_q;
	logic [NPORTS-1:0] msi_pend;
	// Combinational
	logic [NPORTS-1:0] cond;
	logic [NPORTS-1:0] live;
	logic [3:0]        up_agg;
	logic [NPORTS-1:0] hp_s;
	logic [NPORTS-1:0] up_s;
	logic [NPORTS-1:0] part_s;
	logic [NPORTS*4-1:0] ext_s;
	logic        wr;
	logic        rd_go;
	logic [31:0] wmask;
	logic [31:0] next_dat;
	logic [2:0]  ev;

	// Byte-enable mask for writes
	always_comb begin
		wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	end

	// Writes land at the edge that sees ack high, the same edge at which the master samples it
	assign wr    = cyc_i & stb_i & we_i & ack_o;
	assign rd_go = cyc_i & stb_i & ~ack_o;

	// Two-stage synchroniser for the hot-plug, link-up, partition and external INTx pins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1 <= '0;
			sync2 <= '0;
		end else if (ce_i) begin
			sync1 <= {ext_intx_i, in_part_i, dl_up_i, hp_irq_i};
			sync2 <= sync1;
		end
	end
	assign hp_s   = sync2[NPORTS-1:0];
	assign up_s   = sync2[2*NPORTS-1:NPORTS];
	assign part_s = sync2[3*NPORTS-1:2*NPORTS];
	assign ext_s  = sync2[7*NPORTS-1:3*NPORTS];

	// Port live only when link up and still in the partition
	assign live = up_s & part_s;

	// Per-port unmasked condition
	always_comb begin
		for (int p = 0; p < NPORTS; p++) begin
			cond[p] = hp_s[p]
				| (link_bw[2*p]   & ctrl[4*p+`SPIA_CTRL_BWNEN])
				| (link_bw[2*p+1] & ctrl[4*p+`SPIA_CTRL_ABWNEN]);
			cond[p] = cond[p] & live[p];
		end
	end

	// Condition edge tracking and MSI/INTA decisions
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cond_q   <= '0;
			inta_q   <= '0;
			msi_pend <= '0;
		end else if (ce_i) begin
			cond_q <= cond;
			// Clear the request just sent first, so that a new rise in the same cycle wins
			for (int p = 0; p < NPORTS; p++) begin
				if (msi_req_o.valid && 3'(p) == msi_req_o.port) begin
					msi_pend[p] <= 1'b0;
				end
			end
			for (int p = 0; p < NPORTS; p++) begin
				if (cond[p] & ~cond_q[p]) begin
					if (ctrl[4*p+`SPIA_CTRL_MSIEN]) begin
						msi_pend[p] <= 1'b1;
					end else if (!ctrl[4*p+`SPIA_CTRL_INTXDIS]) begin
						inta_q[p] <= 1'b1;
					end
				end else if (~cond[p] & cond_q[p]) begin
					if (!ctrl[4*p+`SPIA_CTRL_MSIEN] && !ctrl[4*p+`SPIA_CTRL_INTXDIS]) begin
						inta_q[p] <= 1'b0;
					end
				end
				if (!live[p]) begin
					inta_q[p] <= 1'b0;
				end
			end
		end
	end

	// Swizzle and OR into upstream wires; port p wire i lands on upstream wire (i + p) mod 4
	always_comb begin
		up_agg = '0;
		for (int p = 0; p < NPORTS; p++) begin
			for (int i = 0; i < 4; i++) begin
				// Port's own INTA joins external wire A
				if (live[p] & (ext_s[4*p+i] | (i == 0 && inta_q[p]))) begin
					up_agg[2'(i + p)] = 1'b1;
				end
			end
		end
	end

	// Aggregated wire state and message sender, one message per cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			up_q       <= '0;
			sent_q     <= '0;
			intx_msg_o <= '0;
		end else if (ce_i) begin
			up_q       <= up_agg;
			intx_msg_o <= '0;
			for (int w = 3; w >= 0; w--) begin
				if (up_q[w] != sent_q[w]) begin
					intx_msg_o.valid             <= 1'b1;
					intx_msg_o.assert_n_deassert <= up_q[w];
					intx_msg_o.wire_idx          <= 2'(w);
				end
			end
			for (int w = 0; w < 4; w++) begin
				if (up_q[w] != sent_q[w]) begin
					// Lowest differing wire is sent this cycle
					sent_q[w] <= up_q[w];
					break;
				end
			end
		end
	end

	// MSI request issue toward upstream port, lowest port first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			msi_req_o <= '0;
		end else if (ce_i) begin
			msi_req_o <= '0;
			if (!msi_req_o.valid) begin
				for (int p = NPORTS - 1; p >= 0; p--) begin
					if (msi_pend[p]) begin
						msi_req_o.valid <= 1'b1;
						msi_req_o.port  <= 3'(p);
					end
				end
			end
		end
	end

	// Interrupt events: MSI sent, assert sent, deassert sent
	always_comb begin
		ev = '0;
		ev[`SPIA_IRQ_MSI]      = msi_req_o.valid;
		ev[`SPIA_IRQ_ASSERT]   = intx_msg_o.valid & intx_msg_o.assert_n_deassert;
		ev[`SPIA_IRQ_DEASSERT] = intx_msg_o.valid & ~intx_msg_o.assert_n_deassert;
	end

	// Register writes; sticky set wins over W1C clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl    <= `SPIA_RST_CTRL;
			mask    <= `SPIA_RST_MASK;
			status  <= '0;
			msi_lo  <= '0;
			msi_hi  <= '0;
			link_bw <= '0;
		end else if (ce_i) begin
			if (wr && adr_i == `SPIA_OFF_CTRL) begin
				ctrl <= (ctrl & ~wmask) | (dat_i & wmask);
			end else if (wr && adr_i == `SPIA_OFF_MASK) begin
				mask <= (mask & ~wmask) | (dat_i & wmask);
			end else if (wr && adr_i == `SPIA_OFF_MSI_ADDRESS_LOW) begin
				msi_lo <= (msi_lo & ~wmask) | (dat_i & wmask);
			end else if (wr && adr_i == `SPIA_OFF_MSIADDRH) begin
				msi_hi <= (msi_hi & ~wmask) | (dat_i & wmask);
			end
			if (wr && adr_i == `SPIA_OFF_STATUS) begin
				status <= (status & ~(dat_i & wmask)) | {29'h0, ev};
			end else begin
				status <= status | {29'h0, ev};
			end
			// Link bandwidth bits: software pulses set via high half, W1C low half
			if (wr && adr_i == `SPIA_OFF_LINK) begin
				link_bw <= (link_bw & ~(dat_i[2*NPORTS-1:0] & wmask[2*NPORTS-1:0]))
					| dat_i[16+2*NPORTS-1:16];
			end
		end
	end

	// Read mux and single-cycle ack
	always_comb begin
		if (adr_i == `SPIA_OFF_CTRL) begin
			next_dat = ctrl;
		end else if (adr_i == `SPIA_OFF_LINK) begin
			next_dat = 32'(link_bw);
		end else if (adr_i == `SPIA_OFF_STATUS) begin
			next_dat = status;
		end else if (adr_i == `SPIA_OFF_MASK) begin
			next_dat = mask;
		end else if (adr_i == `SPIA_OFF_WIRES) begin
			next_dat = {24'h0, sent_q, up_q};
		end else if (adr_i == `SPIA_OFF_MSI_ADDRESS_LOW) begin
			next_dat = msi_lo;
		end else if (adr_i == `SPIA_OFF_MSIADDRH) begin
			next_dat = msi_hi;
		end else begin
			next_dat = 32'h0000_0000;
		end
	end

	// Bus answer and interrupt output registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			ack_o <= rd_go;
			dat_o <= next_dat;
			irq_o <= |(status & mask);
		end
	end

	// Assertions
	property p_msi_on_rise;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && cond[2] && !cond_q[2] && ctrl[4*2+`SPIA_CTRL_MSIEN]) |=> msi_pend[2] || msi_req_o.valid;
	endproperty
	a_msi_on_rise: assert property (p_msi_on_rise) else $error("MSI not raised");

	property p_inta_on_rise;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && live[1] && cond[1] && !cond_q[1] && !ctrl[4*1+`SPIA_CTRL_MSIEN] && !ctrl[4*1+`SPIA_CTRL_INTXDIS])
			|=> inta_q[1];
	endproperty
	a_inta_on_rise: assert property (p_inta_on_rise) else $error("INTA not asserted");

	property p_inta_dis;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !inta_q[3] && ctrl[4*3+`SPIA_CTRL_INTXDIS] && $stable(ctrl)) |=> !inta_q[3];
	endproperty
	a_inta_dis: assert property (p_inta_dis) else $error("INTA set while disabled");

	property p_inta_fall;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !cond[1] && cond_q[1] && !ctrl[4*1+`SPIA_CTRL_MSIEN] && !ctrl[4*1+`SPIA_CTRL_INTXDIS]) |=> !inta_q[1];
	endproperty
	a_inta_fall: assert property (p_inta_fall) else $error("INTA not deasserted");

	property p_down;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !live[1]) |=> !inta_q[1];
	endproperty
	a_down: assert property (p_down) else $error("Wire held on dead port");

	sequence s_rise;
		ce_i && !sent_q[0] && up_q[0] && $stable(up_q) ##1 ce_i;
	endsequence
	property p_assert_msg;
		@(posedge clk_i) disable iff (rst_i)
		s_rise |-> $past(sent_q[0]) == 1'b0 && (sent_q[0] || !$past(up_q[0]));
	endproperty
	a_assert_msg: assert property (p_assert_msg) else $error("Assert message missing");

	property p_deassert_msg;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && intx_msg_o.valid && !intx_msg_o.assert_n_deassert) |-> |($past(sent_q) & (4'h1 << intx_msg_o.wire_idx));
	endproperty
	a_deassert_msg: assert property (p_deassert_msg) else $error("Deassert without assert");

	property p_swizzle;
		@(posedge clk_i) disable iff (rst_i)
		(live[0] && ext_s[0]) |-> up_agg[0];
	endproperty
	a_swizzle: assert property (p_swizzle) else $error("Port 0 wire A not mapped to A");

	property p_irq;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && |(status & mask)) |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt output missing");

	// MSI mode never raises the virtual wire
	property p_msi_no_wire;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && cond[2] && !cond_q[2] && ctrl[4*2+`SPIA_CTRL_MSIEN] && !inta_q[2]) |=> !inta_q[2];
	endproperty
	a_msi_no_wire: assert property (p_msi_no_wire) else $error("Wire raised in MSI mode");

	// Port 1 wire A lands on upstream wire B
	property p_rotate;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && live[1] && ext_s[4]) |=> up_q[1];
	endproperty
	a_rotate: assert property (p_rotate) else $error("Port 1 wire A not mapped to wire B");

	// Wire B differs from what was sent while wire A is settled: B goes out next
	sequence s_b_rise;
		ce_i && up_q[1] && !sent_q[1] && (up_q[0] == sent_q[0]);
	endsequence
	sequence s_b_fall;
		ce_i && !up_q[1] && sent_q[1] && (up_q[0] == sent_q[0]);
	endsequence
	property p_b_assert;
		@(posedge clk_i) disable iff (rst_i)
		s_b_rise |=> intx_msg_o.valid && intx_msg_o.assert_n_deassert && intx_msg_o.wire_idx == 2'd1;
	endproperty
	a_b_assert: assert property (p_b_assert) else $error("Assert for wire B missing");
	property p_b_deassert;
		@(posedge clk_i) disable iff (rst_i)
		s_b_fall |=> intx_msg_o.valid && !intx_msg_o.assert_n_deassert && intx_msg_o.wire_idx == 2'd1;
	endproperty
	a_b_deassert: assert property (p_b_deassert) else $error("Deassert for wire B missing");

	// Bus answer is a single-cycle pulse
	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && ack_o) |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held too long");

	// Sticky MSI status holds until written with a one
	property p_sticky;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && status[`SPIA_IRQ_MSI] && !(wr && adr_i == `SPIA_OFF_STATUS && dat_i[`SPIA_IRQ_MSI] && sel_i[0]))
			|=> status[`SPIA_IRQ_MSI];
	endproperty
	a_sticky: assert property (p_sticky) else $error("Sticky status lost");

	// Clock enable low freezes wire state and outputs
	property p_freeze;
		@(posedge clk_i) disable iff (rst_i)
		!ce_i |=> $stable(up_q) && $stable(sent_q) && $stable(intx_msg_o) && $stable(ack_o);
	endproperty
	a_freeze: assert property (p_freeze) else $error("State moved with enable low");
endmodule // spia_aggregator

// File: spia_root_model.sv
`timescale 1ns/1ps
module spia_root_model (
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// Messages from the upstream port
	input  wire spia_pkg::spia_intx_msg_t intx_msg_i,
	input  wire spia_pkg::spia_msi_req_t  msi_req_i,
	// Tallies read by the bench
	output int                            proto_err_o,
	output int                            msi_cnt_o
);
	// Wire levels as the root sees them
	logic [3:0] wire_st;

	// A message that does not change its wire is a protocol fault
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wire_st     <= 4'h0;
			proto_err_o <= 0;
			msi_cnt_o   <= 0;
		end else begin
			if (intx_msg_i.valid) begin
				if (wire_st[intx_msg_i.wire_idx] == intx_msg_i.assert_n_deassert) begin
					proto_err_o <= proto_err_o + 1;
				end
				wire_st[intx_msg_i.wire_idx] <= intx_msg_i.assert_n_deassert;
			end
			// Every MSI write is accepted at the root
			if (msi_req_i.valid) begin
				msi_cnt_o <= msi_cnt_o + 1;
			end
		end
	end
endmodule // spia_root_model

// File: test_switch_port_intx_msi_aggregator.sv
`timescale 1ns/1ps
`include "spia_map.svh"
module test_switch_port_intx_msi_aggregator;
	// Clock, reset and bus
	logic                     clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, irq_o;
	logic [7:0]               adr_i;
	logic [3:0]               sel_i, hp_irq_i, dl_up_i, in_part_i;
	logic [31:0]              dat_i, dat_o, rd;
	logic [15:0]              ext_intx_i;
	spia_pkg::spia_intx_msg_t intx_msg_o;
	spia_pkg::spia_msi_req_t  msi_req_o;
	// Expected messages, oldest first
	logic [3:0]               q_x[$];
	logic [3:0]               q_m[$];
	int                       num_errors, n_checks, seed, root_err, root_msi, r, c, ma;

	spia_aggregator #(.NPORTS(4)) i_spia_aggregator (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .hp_irq_i, .dl_up_i, .in_part_i, .ext_intx_i, .intx_msg_o,
		.msi_req_o, .irq_o);
	spia_root_model i_spia_root_model (.clk_i, .rst_i, .intx_msg_i(intx_msg_o), .msi_req_i(msi_req_o),
		.proto_err_o(root_err), .msi_cnt_o(root_msi));

	// Free-running clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Compare and count
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask

	// Compare one message against its note
	task chk_msg(input string s, input logic [3:0] e, input logic [3:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask

	// Verdict and end of run
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One classic cycle, held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		// Ack seen high at an edge ends this wait; the watchdog ends it if ack never comes
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	// Note an expected wire message
	task ex(input logic a, input int w);
		q_x.push_back({1'b1, a, w[1:0]});
	endtask

	// Wait for the notes to drain, then for stray messages
	task settle;
		int n;
		n = 0;
		while (q_x.size() + q_m.size() != 0 && n < 60) begin
			@(posedge clk_i);
			n++;
		end
		repeat (10) @(posedge clk_i);
		chk("pending", 0, q_x.size() + q_m.size());
	endtask

	// Drive all port pins, then settle
	task drv(input logic [3:0] hp, input logic [15:0] e, input logic [3:0] up, input logic [3:0] pt);
		@(posedge clk_i);
		hp_irq_i   <= hp;
		ext_intx_i <= e;
		dl_up_i    <= up;
		in_part_i  <= pt;
		settle;
	endtask

	// Each message taken against the oldest note
	always @(posedge clk_i) begin
		if (rst_i === 1'b0 && intx_msg_o.valid !== 1'b0) begin
			chk_msg("intx_msg", q_x.size() ? q_x.pop_front() : 4'h0, intx_msg_o);
		end
		if (rst_i === 1'b0 && msi_req_o.valid !== 1'b0) begin
			chk_msg("msi_req", q_m.size() ? q_m.pop_front() : 4'h0, msi_req_o);
		end
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		report_and_stop;
	end

	// Main sequence
	initial begin
		seed = 32'h6bc2;
		{rst_i, ce_i, sel_i} = 6'h3F;
		{cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
		{hp_irq_i, ext_intx_i, dl_up_i, in_part_i} = {20'h0, 8'hFF};
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("irq", 0, irq_o);
		wb(0, `SPIA_OFF_CTRL, 0);
		chk("ctrl", `SPIA_RST_CTRL, rd);
		wb(0, `SPIA_OFF_MASK, 0);
		chk("mask", `SPIA_RST_MASK, rd);
		wb(0, 8'hFC, 0);
		chk("unmapped", 0, rd);
		ma = $random(seed);
		wb(1, `SPIA_OFF_MSI_ADDRESS_LOW, ma);
		wb(1, `SPIA_OFF_MSIADDRH, ~ma);
		wb(0, `SPIA_OFF_MSI_ADDRESS_LOW, 0);
		chk("msi_address_low", ma, rd);
		wb(0, `SPIA_OFF_MSIADDRH, 0);
		chk("msi_address_high", ~ma, rd);
		// Every port and wire, in a random rotation
		r = $random(seed);
		for (int k = 0; k < 16; k++) begin
			c = (k + r) & 15;
			ex(1, (c + c / 4) % 4);
			drv(0, 16'h1 << c, 4'hF, 4'hF);
			ex(0, (c + c / 4) % 4);
			drv(0, 0, 4'hF, 4'hF);
		end
		// Clock enable low: nothing moves until it returns
		ex(1, 3);
		@(posedge clk_i);
		ce_i       <= 1'b0;
		ext_intx_i <= 16'h0008;
		repeat (8) @(posedge clk_i);
		chk("frozen", 1, q_x.size());
		ce_i <= 1'b1;
		settle;
		ex(0, 3);
		drv(0, 0, 4'hF, 4'hF);
		// Two wires together: lower index first
		ex(1, 0);
		ex(1, 2);
		drv(0, 16'h0005, 4'hF, 4'hF);
		ex(0, 0);
		ex(0, 2);
		drv(0, 0, 4'hF, 4'hF);
		// Port 1 hot-plug and port 0 INTB share upstream wire 1
		ex(1, 1);
		drv(4'h2, 0, 4'hF, 4'hF);
		drv(4'h2, 16'h2, 4'hF, 4'hF);
		wb(0, `SPIA_OFF_WIRES, 0);
		chk("wires", 32'h22, rd);
		drv(0, 16'h2, 4'hF, 4'hF);
		ex(0, 1);
		drv(0, 0, 4'hF, 4'hF);
		// Link down and removal negate the wires
		ex(1, 0);
		drv(0, 16'h1, 4'hF, 4'hF);
		ex(0, 0);
		drv(0, 16'h1, 4'hE, 4'hF);
		drv(0, 0, 4'hE, 4'hF);
		drv(0, 0, 4'hF, 4'hF);
		ex(1, 1);
		drv(4'h2, 0, 4'hF, 4'hF);
		ex(0, 1);
		drv(4'h2, 0, 4'hF, 4'hD);
		drv(0, 0, 4'hF, 4'hD);
		drv(0, 0, 4'hF, 4'hF);
		// Bandwidth status: only the enabled bit counts
		wb(1, `SPIA_OFF_CTRL, 32'h40);
		ex(1, 1);
		wb(1, `SPIA_OFF_LINK, 32'h000C_0000);
		settle;
		ex(0, 1);
		wb(1, `SPIA_OFF_LINK, 32'h0000_000C);
		settle;
		// MSI on port 2, legacy disabled on port 3
		wb(1, `SPIA_OFF_CTRL, 32'h0000_2100);
		q_m.push_back({1'b1, 3'd2});
		drv(4'hC, 0, 4'hF, 4'hF);
		drv(0, 0, 4'hF, 4'hF);
		// Status, mask and the interrupt line
		wb(0, `SPIA_OFF_STATUS, 0);
		chk("status", 32'h7, rd);
		wb(1, `SPIA_OFF_MASK, 32'h7);
		repeat (2) @(posedge clk_i);
		chk("irq", 1, irq_o);
		wb(1, `SPIA_OFF_STATUS, 32'h7);
		repeat (2) @(posedge clk_i);
		chk("irq", 0, irq_o);
		chk("root_err", 0, root_err);
		chk("root_msi", 1, root_msi);
		report_and_stop;
	end
endmodule // test_switch_port_intx_msi_aggregator
